// ===== hw/xpd_pkg.sv
// Package for the internal peripheral bus enable and address steering block.
// Assumes a 32-bit APB slave port and a 24-bit CPU address on the same clock.
`default_nettype none
package xpd_pkg;

    // APB register byte offsets
    localparam logic [11:0] OFF_PERIPH_SELECT = 12'h000;
    localparam logic [11:0] OFF_SYSTEM_CONFIG = 12'h004;
    localparam logic [11:0] OFF_TK_CONTROL    = 12'h008;
    localparam logic [11:0] OFF_STATUS        = 12'h00C;

    // Peripheral select field positions
    localparam int SEL_FIRST_CAN  = 0;
    localparam int SEL_SECOND_CAN = 1;
    localparam int SEL_SMALL_RAM  = 2;
    localparam int SEL_LARGE_RAM  = 3;
    localparam int SEL_TIMEKEEPER = 4;
    localparam int SEL_WIDTH      = 5;

    // Other field positions
    localparam int SYSCFG_GLOBAL_EN  = 2;
    localparam int TKCTL_OSC_OFF_SEL = 0;
    localparam int STAT_GLOBAL_EN    = 5;
    localparam int STAT_EMULATION    = 6;
    localparam int STAT_PINS         = 7;
    localparam int STAT_OSC_STOP     = 11;

    // Values after reset and in emulation
    localparam logic [4:0] SELECT_RESET   = 5'h05;
    localparam logic [4:0] SELECT_ALL_ON  = 5'h1F;
    localparam logic       GLOBAL_RESET   = 1'h0;
    localparam logic       OSC_SEL_RESET  = 1'h0;

    // Address windows, index order: large RAM, small RAM, second CAN, first CAN
    localparam int WIN_LARGE_RAM  = 0;
    localparam int WIN_SMALL_RAM  = 1;
    localparam int WIN_SECOND_CAN = 2;
    localparam int WIN_FIRST_CAN  = 3;
    localparam int WIN_COUNT      = 4;
    localparam logic [23:0] WIN_BASE [WIN_COUNT] = '{24'h00C000, 24'h00E000,
                                                     24'h00EE00, 24'h00EF00};
    localparam logic [23:0] WIN_LAST [WIN_COUNT] = '{24'h00DFFF, 24'h00E7FF,
                                                     24'h00EEFF, 24'h00EFFF};

    // Where one CPU access is steered
    typedef enum logic [5:0] {
        ROUTE_NONE       = 6'h01,
        ROUTE_EXTERNAL   = 6'h02,
        ROUTE_SMALL_RAM  = 6'h04,
        ROUTE_LARGE_RAM  = 6'h08,
        ROUTE_FIRST_CAN  = 6'h10,
        ROUTE_SECOND_CAN = 6'h20
    } xpd_route_type;

    // Port 4 pins freed for general-purpose use
    typedef struct packed {
        logic p4_7;
        logic p4_6;
        logic p4_5;
        logic p4_4;
    } xpd_pins_type;

endpackage
`default_nettype wire

// ===== hw/xpd_window.sv
// Address window comparator for one internal peripheral.
// Assumes an address stable in the cycle it is compared.
`timescale 1ns/1ns
`default_nettype none
module xpd_window #(
    parameter logic [23:0] BASE = 24'h000000,
    parameter logic [23:0] LAST = 24'h000000
) (
    input  wire logic [23:0] addr,
    output logic             hit
);
    // Inclusive range check
    assign hit = (addr >= BASE) && (addr <= LAST);
endmodule
`default_nettype wire

// ===== hw/xpd_decode.sv
// Internal peripheral bus enable register and address steering.
// Assumes an APB master on clk, CPU access requests on clk, and an asynchronous
// emulation strap pin that is synchronised here.
// Functional notes
// R1: With both CAN enables clear, the whole combined CAN window goes external.
// R2: Second CAN off frees P4.4 and P4.7; first CAN off frees P4.5 and P4.6.
// R3: Reset selects first CAN and small RAM on, second CAN and large RAM off.
// R4: Once the global enable is set, writes to the peripheral select are ignored.
// R5: In emulation every peripheral is enabled and the select reads all ones.
// R6: With the timekeeper disabled, power-down stops the clock oscillator.
// R7: With the timekeeper enabled, the off-select bit decides the oscillator.
// R8: Large RAM answers its window only with global and own enable set.
// R9: First CAN occupies its window only with global and own enable set.
// R10: Second CAN occupies its window only with global and own enable set.
// R11: Small RAM enable clear sends its window external, set with global enable serves it inside.
//
// Decided for this implementation: the APB interface to the registers and the register offsets.
`timescale 1ns/1ns
`default_nettype none
module xpd_decode (
    input  wire logic                  clk,
    input  wire logic                  rst_n,
    input  wire logic                  psel,
    input  wire logic                  penable,
    input  wire logic                  pwrite,
    input  wire logic [11:0]           paddr,
    input  wire logic [31:0]           pwdata,
    output logic                       pready,
    output logic [31:0]                prdata,
    output logic                       pslverr,
    input  wire logic                  emulation_pin,
    input  wire logic                  power_down,
    input  wire logic                  cpu_req,
    input  wire logic [23:0]           cpu_addr,
    output var xpd_pkg::xpd_route_type route,
    output var xpd_pkg::xpd_pins_type  pins_free,
    output logic                       osc_stop
);

    // Register state
    logic [4:0]  select;
    logic        global_en;
    logic        osc_off_select;
    logic [4:0]  next_select;
    logic        next_global_en;
    logic        next_osc_off_select;
    logic        next_pready;
    logic [31:0] next_prdata;
    logic        next_pslverr;

    // Steering state
    xpd_pkg::xpd_route_type next_route;
    xpd_pkg::xpd_pins_type  next_pins_free;
    logic                   next_osc_stop;

    // Emulation strap synchroniser
    logic emu_meta;
    logic emu_sync;

    // Effective enables
    logic [4:0] eff_select;
    logic       large_on;
    logic       small_on;
    logic       first_can_module_on;
    logic       second_can_module_on;
    logic       tk_on;
    logic [xpd_pkg::WIN_COUNT-1:0] win_hit;

    // Bus handshake terms
    logic setup_phase;
    logic write_go;

    // Two stages before anything reads the emulation pin
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            emu_meta <= 1'h0;
            emu_sync <= 1'h0;
        end else begin
            emu_meta <= emulation_pin;
            emu_sync <= emu_meta;
        end
    end

    // Emulation overrides the stored select
    always_comb begin
        eff_select = emu_sync ? xpd_pkg::SELECT_ALL_ON : select; // see R5
        large_on   = global_en && eff_select[xpd_pkg::SEL_LARGE_RAM];  // see R8
        small_on   = global_en && eff_select[xpd_pkg::SEL_SMALL_RAM];  // see R11
        first_can_module_on    = global_en && eff_select[xpd_pkg::SEL_FIRST_CAN];  // see R9
        second_can_module_on    = global_en && eff_select[xpd_pkg::SEL_SECOND_CAN]; // see R10
        tk_on      = eff_select[xpd_pkg::SEL_TIMEKEEPER];
    end

    // One comparator per peripheral window
    generate
        for (genvar w = 0; w < xpd_pkg::WIN_COUNT; w++) begin : g_win
            xpd_window #(
                .BASE (xpd_pkg::WIN_BASE[w]),
                .LAST (xpd_pkg::WIN_LAST[w])
            ) u_win (
                .addr (cpu_addr),
                .hit  (win_hit[w])
            );
        end
    endgenerate

    // Answer one cycle after setup, so every access has one access cycle
    assign setup_phase = psel && !penable;
    assign write_go    = psel && penable && pready && pwrite;

    // Register file next values
    always_comb begin
        next_select         = select;
        next_global_en      = global_en;
        next_osc_off_select = osc_off_select;
        next_pready         = setup_phase;
        next_prdata         = 32'h00000000;
        next_pslverr        = 1'h0;
        if (write_go) begin
            unique case (paddr)
                xpd_pkg::OFF_PERIPH_SELECT: begin
                    // Frozen after the global enable, so a stray write cannot
                    // move a live peripheral window
                    if (!global_en) begin
                        next_select = pwdata[4:0]; // see R4
                    end
                end
                xpd_pkg::OFF_SYSTEM_CONFIG: begin
                    next_global_en = pwdata[xpd_pkg::SYSCFG_GLOBAL_EN];
                end
                xpd_pkg::OFF_TK_CONTROL: begin
                    next_osc_off_select = pwdata[xpd_pkg::TKCTL_OSC_OFF_SEL];
                end
                default: begin
                    next_select = select; // Status and unmapped: no effect
                end
            endcase
        end
        if (setup_phase) begin
            unique case (paddr)
                xpd_pkg::OFF_PERIPH_SELECT: begin
                    next_prdata[4:0] = eff_select; // see R5
                end
                xpd_pkg::OFF_SYSTEM_CONFIG: begin
                    next_prdata[xpd_pkg::SYSCFG_GLOBAL_EN] = global_en;
                end
                xpd_pkg::OFF_TK_CONTROL: begin
                    next_prdata[xpd_pkg::TKCTL_OSC_OFF_SEL] = osc_off_select;
                end
                xpd_pkg::OFF_STATUS: begin
                    next_prdata[4:0]                        = eff_select;
                    next_prdata[xpd_pkg::STAT_GLOBAL_EN]    = global_en;
                    next_prdata[xpd_pkg::STAT_EMULATION]    = emu_sync;
                    next_prdata[xpd_pkg::STAT_PINS +: 4]    = pins_free;
                    next_prdata[xpd_pkg::STAT_OSC_STOP]     = osc_stop;
                end
                default: begin
                    next_pslverr = 1'h1; // Unmapped address
                end
            endcase
        end
    end

    // Register file storage
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            select         <= xpd_pkg::SELECT_RESET; // see R3
            global_en      <= xpd_pkg::GLOBAL_RESET;
            osc_off_select <= xpd_pkg::OSC_SEL_RESET;
            pready         <= 1'h0;
            prdata         <= 32'h00000000;
            pslverr        <= 1'h0;
        end else begin
            select         <= next_select;
            global_en      <= next_global_en;
            osc_off_select <= next_osc_off_select;
            pready         <= next_pready;
            prdata         <= next_prdata;
            pslverr        <= next_pslverr;
        end
    end

    // Steering, pin release and oscillator control next values
    always_comb begin
        next_route = xpd_pkg::ROUTE_NONE;
        if (cpu_req) begin
            if (win_hit[xpd_pkg::WIN_LARGE_RAM]) begin
                next_route = large_on ? xpd_pkg::ROUTE_LARGE_RAM
                                      : xpd_pkg::ROUTE_EXTERNAL; // see R8
            end else if (win_hit[xpd_pkg::WIN_SMALL_RAM]) begin
                next_route = small_on ? xpd_pkg::ROUTE_SMALL_RAM
                                      : xpd_pkg::ROUTE_EXTERNAL; // see R11
            end else if (win_hit[xpd_pkg::WIN_FIRST_CAN] ||
                         win_hit[xpd_pkg::WIN_SECOND_CAN]) begin
                // One CAN off alone leaves its window dead, not external
                if (!first_can_module_on && !second_can_module_on) begin
                    next_route = xpd_pkg::ROUTE_EXTERNAL; // see R1
                end else if (win_hit[xpd_pkg::WIN_FIRST_CAN] && first_can_module_on) begin
                    next_route = xpd_pkg::ROUTE_FIRST_CAN; // see R9
                end else if (win_hit[xpd_pkg::WIN_SECOND_CAN] && second_can_module_on) begin
                    next_route = xpd_pkg::ROUTE_SECOND_CAN; // see R10
                end else begin
                    next_route = xpd_pkg::ROUTE_NONE;
                end
            end else begin
                next_route = xpd_pkg::ROUTE_NONE;
            end
        end
        // Pins stay with a CAN only while it is live
        next_pins_free.p4_4 = !second_can_module_on; // see R2
        next_pins_free.p4_7 = !second_can_module_on; // see R2
        next_pins_free.p4_5 = !first_can_module_on; // see R2
        next_pins_free.p4_6 = !first_can_module_on; // see R2
        // Default stop in power-down unless the timekeeper needs the oscillator
        if (!power_down) begin
            next_osc_stop = 1'h0;
        end else if (!tk_on) begin
            next_osc_stop = 1'h1; // see R6
        end else begin
            next_osc_stop = osc_off_select; // see R7
        end
    end

    // Steering storage
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            route     <= xpd_pkg::ROUTE_NONE;
            pins_free <= 4'hF;
            osc_stop  <= 1'h0;
        end else begin
            route     <= next_route;
            pins_free <= next_pins_free;
            osc_stop  <= next_osc_stop;
        end
    end

    // Checks on what this block drives
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);

    reset_select_a: assert property (!$past(rst_n) |-> select == 5'h05) // see R3
        else $error("select not at reset value after reset");
    select_lock_a: assert property (global_en && write_go &&      // see R4
        paddr == 12'h000 |=> $stable(select))
        else $error("select changed after global enable");
    emu_read_a: assert property (emu_sync && $stable(emu_sync) && setup_phase && // see R5
        paddr == 12'h000 |=> pready && prdata[4:0] == 5'h1F)
        else $error("select does not read all ones in emulation");
    can_external_a: assert property (cpu_req && cpu_addr >= 24'h00EE00 && // see R1
        cpu_addr <= 24'h00EFFF && !first_can_module_on && !second_can_module_on
        |=> route == xpd_pkg::ROUTE_EXTERNAL)
        else $error("combined CAN window not external");
    pin_release_a: assert property ((!first_can_module_on && !second_can_module_on) [*2] // see R2
        |-> pins_free == 4'hF)
        else $error("port pins held by a disabled CAN");
    osc_default_a: assert property (power_down && !tk_on |=> osc_stop) // see R6
        else $error("oscillator kept in power-down with timekeeper off");
    osc_select_a: assert property (power_down && tk_on // see R7
        |=> osc_stop == $past(osc_off_select))
        else $error("oscillator ignores off-select");
    large_ram_a: assert property (cpu_req && win_hit[0] // see R8
        |=> route == (($past(large_on)) ? xpd_pkg::ROUTE_LARGE_RAM
                                        : xpd_pkg::ROUTE_EXTERNAL))
        else $error("large RAM window steered wrong");
    first_can_a: assert property (cpu_req && win_hit[3] && first_can_module_on // see R9
        |=> route == xpd_pkg::ROUTE_FIRST_CAN)
        else $error("first CAN window not served");
    second_can_a: assert property (cpu_req && win_hit[2] && second_can_module_on // see R10
        |=> route == xpd_pkg::ROUTE_SECOND_CAN)
        else $error("second CAN window not served");
    small_ram_a: assert property (cpu_req && win_hit[1] && !small_on // see R11
        |=> route == xpd_pkg::ROUTE_EXTERNAL)
        else $error("small RAM window not external when off");
    apb_answer_a: assert property (setup_phase |=> pready ##1 !pready)
        else $error("APB answer not exactly one cycle after setup");

    // Writes land before the freeze, refusals and idle outputs stay quiet
    select_write_a: assert property (!global_en && write_go && // see R4
        paddr == xpd_pkg::OFF_PERIPH_SELECT |=> select == $past(pwdata[4:0]))
        else $error("select write lost before global enable");
    unmapped_err_a: assert property (setup_phase && paddr >= 12'h010
        |=> pready && pslverr && prdata == 32'h00000000)
        else $error("unmapped address not refused");
    route_idle_a: assert property (!cpu_req |=> route == xpd_pkg::ROUTE_NONE)
        else $error("route shown without a request");
    global_off_a: assert property (cpu_req && !global_en && (|win_hit) // see R1
        |=> route == xpd_pkg::ROUTE_EXTERNAL)
        else $error("window not external with global enable clear");
    can_dead_a: assert property (cpu_req && win_hit[xpd_pkg::WIN_SECOND_CAN] && // see R10
        !second_can_module_on && first_can_module_on |=> route == xpd_pkg::ROUTE_NONE)
        else $error("disabled second CAN window not dead");
    // One CAN off alone frees only its own pair of pins
    pins_first_a: assert property ((first_can_module_on && !second_can_module_on) [*2] // see R2
        |-> pins_free == 4'h9)
        else $error("second CAN pins not freed");
    pins_second_a: assert property ((second_can_module_on && !first_can_module_on) [*2] // see R2
        |-> pins_free == 4'h6)
        else $error("first CAN pins not freed");
    osc_run_a: assert property (!power_down |=> !osc_stop) // see R6
        else $error("oscillator stopped outside power-down");

endmodule
`default_nettype wire

// ===== test/xpd_cpu_model.sv
// Partner model of the CPU side: one steering request per call.
// Assumes the bench calls it and that it shares the block's clock.
`timescale 1ns/1ns
`default_nettype none
module xpd_cpu_model (
    input  wire logic                   clk,
    output logic                        cpu_req,
    output logic [23:0]                 cpu_addr,
    input  wire xpd_pkg::xpd_route_type route
);
    // Idle with no request
    initial begin
        cpu_req = 1'b0;
        cpu_addr = 24'hFFFFFF;
    end

    // Address inverted after the request so a stale value never helps
    task automatic access(input logic [23:0] a, output xpd_pkg::xpd_route_type r);
        @(posedge clk);
        cpu_req <= 1'b1;
        cpu_addr <= a;
        @(posedge clk);
        cpu_req <= 1'b0;
        cpu_addr <= ~a;
        @(posedge clk);
        r = route;
    endtask
endmodule
`default_nettype wire

// ===== test/xpd_decode_tb.sv
// Self-checking bench for the peripheral enable and address steering block.
// Assumes the package and the CPU partner model are compiled before it.
`timescale 1ns/1ns
`default_nettype none
module xpd_decode_tb;
    logic                   clk = 1'b0;
    logic                   rst_n = 1'b0;
    logic                   psel = 1'b0;
    logic                   penable = 1'b0;
    logic                   pwrite = 1'b0;
    logic [11:0]            paddr = 12'h000;
    logic [31:0]            pwdata = 32'h00000000;
    logic                   pready;
    logic [31:0]            prdata;
    logic                   pslverr;
    logic                   emulation_pin = 1'b0;
    logic                   power_down = 1'b0;
    logic                   cpu_req;
    logic [23:0]            cpu_addr;
    xpd_pkg::xpd_route_type route;
    xpd_pkg::xpd_pins_type  pins_free;
    logic                   osc_stop;
    int                     num_errors = 0;
    int                     compares = 0;

    // 100 MHz clock
    always #5 clk = ~clk;

    xpd_decode xpd_decode_inst (.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
        .pslverr(pslverr), .emulation_pin(emulation_pin), .power_down(power_down),
        .cpu_req(cpu_req), .cpu_addr(cpu_addr), .route(route), .pins_free(pins_free),
        .osc_stop(osc_stop));
    xpd_cpu_model xpd_cpu_model_inst (.clk(clk), .cpu_req(cpu_req), .cpu_addr(cpu_addr),
        .route(route));

    // Word compare, case equality so unknowns fail
    task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
        compares++;
        if (got !== exp) begin
            num_errors++;
            $display("[ERR] %0t %s: got %h expected %h", $time, what, got, exp);
        end
    endtask

    // APB transfer; waits on pready with no assumed latency
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd,
                       output logic [31:0] rd, output logic err);
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] rd;
        logic        err;
        apb(1'b1, a, d, rd, err);
    endtask

    task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp, input string what);
        logic [31:0] rd;
        logic        err;
        apb(1'b0, a, 32'h00000000, rd, err);
        check(rd, exp, what);
    endtask

    task automatic route_chk(input logic [23:0] a, input xpd_pkg::xpd_route_type exp);
        xpd_pkg::xpd_route_type r;
        xpd_cpu_model_inst.access(a, r);
        check({26'h0, r}, {26'h0, exp}, "route");
    endtask

    // Pins and oscillator follow after one cycle; three give margin
    task automatic out_chk(input logic [3:0] pins, input logic osc);
        repeat (3) @(posedge clk);
        check({28'h0, pins_free}, {28'h0, pins}, "pins_free");
        check({31'h0, osc_stop}, {31'h0, osc}, "osc_stop");
    endtask

    // Select rewrite needs the global enable cleared first
    task automatic set_select(input logic [31:0] sel);
        wr(xpd_pkg::OFF_SYSTEM_CONFIG, 32'h00000000);
        wr(xpd_pkg::OFF_PERIPH_SELECT, sel);
        wr(xpd_pkg::OFF_SYSTEM_CONFIG, 32'h00000004);
    endtask

    task automatic test_reset();
        rd_chk(xpd_pkg::OFF_PERIPH_SELECT, 32'h00000005, "select reset");
        rd_chk(xpd_pkg::OFF_SYSTEM_CONFIG, 32'h00000000, "global reset");
        out_chk(4'hF, 1'b0);
        route_chk(24'h00C000, xpd_pkg::ROUTE_EXTERNAL);
        route_chk(24'h00E000, xpd_pkg::ROUTE_EXTERNAL);
        route_chk(24'h001000, xpd_pkg::ROUTE_NONE);
        $display("test reset done");
    endtask

    task automatic test_enabled();
        set_select(32'h0000000F);
        route_chk(24'h00C000, xpd_pkg::ROUTE_LARGE_RAM);
        route_chk(24'h00DFFF, xpd_pkg::ROUTE_LARGE_RAM);
        route_chk(24'h00E7FF, xpd_pkg::ROUTE_SMALL_RAM);
        route_chk(24'h00E800, xpd_pkg::ROUTE_NONE);
        route_chk(24'h00EF00, xpd_pkg::ROUTE_FIRST_CAN);
        route_chk(24'h00EFFF, xpd_pkg::ROUTE_FIRST_CAN);
        route_chk(24'h00EEFF, xpd_pkg::ROUTE_SECOND_CAN);
        out_chk(4'h0, 1'b0);
        wr(xpd_pkg::OFF_PERIPH_SELECT, 32'h00000000);
        rd_chk(xpd_pkg::OFF_PERIPH_SELECT, 32'h0000000F, "frozen select");
        route_chk(24'h00C000, xpd_pkg::ROUTE_LARGE_RAM);
        $display("test enabled done");
    endtask

    task automatic test_can();
        set_select(32'h00000001);
        out_chk(4'h9, 1'b0);
        route_chk(24'h00EE00, xpd_pkg::ROUTE_NONE);
        set_select(32'h00000002);
        out_chk(4'h6, 1'b0);
        set_select(32'h00000000);
        out_chk(4'hF, 1'b0);
        route_chk(24'h00EE00, xpd_pkg::ROUTE_EXTERNAL);
        route_chk(24'h00EFFF, xpd_pkg::ROUTE_EXTERNAL);
        route_chk(24'h00E7FF, xpd_pkg::ROUTE_EXTERNAL);
        route_chk(24'h00C000, xpd_pkg::ROUTE_EXTERNAL);
        $display("test can done");
    endtask

    task automatic test_osc();
        power_down <= 1'b1;
        out_chk(4'hF, 1'b1);
        power_down <= 1'b0;
        out_chk(4'hF, 1'b0);
        set_select(32'h00000010);
        power_down <= 1'b1;
        out_chk(4'hF, 1'b0);
        wr(xpd_pkg::OFF_TK_CONTROL, 32'h00000001);
        out_chk(4'hF, 1'b1);
        rd_chk(xpd_pkg::OFF_TK_CONTROL, 32'h00000001, "off select");
        rd_chk(xpd_pkg::OFF_STATUS, 32'h00000FB0, "status osc");
        power_down <= 1'b0;
        $display("test osc done");
    endtask

    task automatic test_emul();
        emulation_pin <= 1'b1;
        repeat (6) @(posedge clk);
        rd_chk(xpd_pkg::OFF_PERIPH_SELECT, 32'h0000001F, "emulation select");
        route_chk(24'h00C000, xpd_pkg::ROUTE_LARGE_RAM);
        route_chk(24'h00EE00, xpd_pkg::ROUTE_SECOND_CAN);
        out_chk(4'h0, 1'b0);
        rd_chk(xpd_pkg::OFF_STATUS, 32'h0000007F, "status emul");
        emulation_pin <= 1'b0;
        $display("test emul done");
    endtask

    task automatic test_unmapped();
        logic [31:0] rd;
        logic        err;
        apb(1'b0, 12'h010, 32'h00000000, rd, err);
        check({31'h0, err}, 32'h00000001, "unmapped error");
        check(rd, 32'h00000000, "unmapped data");
        $display("test unmapped done");
    endtask

    // Single closing point for the run
    task automatic report_and_stop();
        $display("compares %0d errors %0d", compares, num_errors);
        if (num_errors == 0 && compares > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    // Watchdog well beyond the fewer than two hundred cycles the tests need
    initial begin
        repeat (20000) @(posedge clk);
        num_errors++;
        $display("[ERR] %0t watchdog expired", $time);
        report_and_stop();
    end

    // Main sequence
    initial begin
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        test_reset();
        test_enabled();
        test_can();
        test_osc();
        test_emul();
        test_unmapped();
        report_and_stop();
    end
endmodule
`default_nettype wire
